// ---- design/xma_alu.sv ----
// Extended memory ALU: APB slave, sequencer and datapath over its data memory
//
// Contract
// RULE_01: Rotate left into accumulator, bit 7 wraps to bit 0, memory and flags kept.
// RULE_02: Rotate memory left through carry; old carry to bit 0, bit 7 to carry.
// RULE_03: Accumulator form of rotate-left-through-carry; memory untouched, carry from bit 7.
// RULE_04: Rotate memory right in place, bit 0 wraps to bit 7, no flags.
// RULE_05: Rotate right into accumulator, memory and flags unchanged.
// RULE_06: Rotate right through carry, memory or accumulator form; only carry changes.
// RULE_07: Accumulator minus memory minus inverted carry; six flags updated.
// RULE_08: Subtract clears carry on negative result, sets it otherwise.
// RULE_09: Plain subtract without carry, to accumulator or memory, six flags.
// RULE_10: Decrement memory in place, skip next when zero, flags unchanged.
// RULE_11: Decrement into accumulator only, skip next when zero.
// RULE_12: Increment memory in place, skip next when zero, flags unchanged.
// RULE_13: Increment into accumulator only, skip next when zero.
// RULE_14: Every skip-type instruction takes two instruction cycles.
// RULE_15: Byte set writes all ones, flags unchanged.
// RULE_16: Bit set forces only the selected bit to one.
// RULE_17: Skip next when selected memory bit is nonzero.
// RULE_18: Skip next when whole memory byte is nonzero.
// RULE_19: Nibble swap in place or into accumulator, no flags.
// RULE_20: Skip next when memory byte is zero, flags untouched.
// RULE_21: Any data memory byte is addressed directly, no banking.
// RULE_22: Taken skip advances past next instruction with a no-operation cycle.
`timescale 1ns/100ps
module xma_alu
    import xma_pkg::*;
#(
    parameter int ADDR_W = xma_pkg::XMA_ADDR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy,
    output logic skip_next
);
    import xma_pkg::*;

    initial begin
        if (ADDR_W < 1 || ADDR_W > 8) begin
            $error("xma_alu: ADDR_W must be 1 to 8");
        end
    end

    xma_state_t state;
    xma_op_t op;
    logic [2:0] bit_sel;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0] acc;
    logic carry, aux_carry_flag, zero, overflow_flag, signed_compare_flag, chained_zero_flag;
    logic [7:0] mem_addr_reg;
    logic [15:0] skips;
    logic last_skip;
    logic [1:0] last_cycles;

    logic [7:0] rdata;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;

    logic apb_setup, apb_access, apb_wr, apb_rd;
    logic addr_ok, refuse;

    // Datapath results
    logic [7:0] result;
    logic to_mem, to_acc, sub_op, skip_op, skip_cond, carry_op;
    logic next_carry;
    logic [8:0] diff;
    logic [4:0] nib_diff;
    logic borrow_in;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite;
    assign apb_rd = apb_access && !pwrite;
    assign busy = (state != st_idle);

    always_comb begin
        case (paddr)
            XMA_OFS_CMD, XMA_OFS_ACC, XMA_OFS_STATUS, XMA_OFS_MEM_ADDR, XMA_OFS_MEM_DATA,
            XMA_OFS_SKIPS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Anything but a status read is refused while an instruction runs
    assign refuse = !addr_ok || (busy && !(paddr == XMA_OFS_STATUS && !pwrite))
        || (pwrite && paddr == XMA_OFS_SKIPS);
    assign pready = 1'b1;
    assign pslverr = apb_access && refuse;

    // Subtraction core shared by all four subtract forms
    assign borrow_in = (op == op_subtract_borrow_to_acc || op == op_subtract_borrow_to_mem) ? !carry : 1'b0; // RULE_07
    assign diff = {1'b0, acc} - {1'b0, rdata} - {8'h00, borrow_in}; // RULE_07 RULE_09
    assign nib_diff = {1'b0, acc[3:0]} - {1'b0, rdata[3:0]} - {4'h0, borrow_in};

    always_comb begin
        result = rdata;
        to_mem = 1'b0;
        to_acc = 1'b0;
        sub_op = 1'b0;
        skip_op = 1'b0;
        skip_cond = 1'b0;
        carry_op = 1'b0;
        next_carry = carry;
        case (op)
            op_rotate_left_to_acc: begin
                result = {rdata[6:0], rdata[7]}; // RULE_01
                to_acc = 1'b1;
            end
            op_rotate_left_carry_mem, op_rotate_left_carry_to_acc: begin
                result = {rdata[6:0], carry}; // RULE_02 RULE_03
                next_carry = rdata[7];
                carry_op = 1'b1;
                to_mem = (op == op_rotate_left_carry_mem);
                to_acc = (op == op_rotate_left_carry_to_acc);
            end
            op_rotate_right_mem, op_rotate_right_to_acc: begin
                result = {rdata[0], rdata[7:1]}; // RULE_04 RULE_05
                to_mem = (op == op_rotate_right_mem);
                to_acc = (op == op_rotate_right_to_acc);
            end
            op_rotate_right_carry_mem, op_rotate_right_carry_to_acc: begin
                result = {carry, rdata[7:1]}; // RULE_06
                next_carry = rdata[0];
                carry_op = 1'b1;
                to_mem = (op == op_rotate_right_carry_mem);
                to_acc = (op == op_rotate_right_carry_to_acc);
            end
            op_subtract_borrow_to_acc, op_subtract_borrow_to_mem, op_subtract_to_acc, op_subtract_to_mem: begin
                result = diff[7:0];
                next_carry = !diff[8]; // RULE_08
                sub_op = 1'b1;
                to_mem = (op == op_subtract_borrow_to_mem || op == op_subtract_to_mem);
                to_acc = !to_mem;
            end
            op_decrement_skip_zero, op_decrement_skip_zero_acc: begin
                result = rdata - 8'h01; // RULE_10 RULE_11
                skip_op = 1'b1;
                skip_cond = (result == 8'h00);
                to_mem = (op == op_decrement_skip_zero);
                to_acc = !to_mem;
            end
            op_increment_skip_zero, op_increment_skip_zero_acc: begin
                result = rdata + 8'h01; // RULE_12 RULE_13
                skip_op = 1'b1;
                skip_cond = (result == 8'h00);
                to_mem = (op == op_increment_skip_zero);
                to_acc = !to_mem;
            end
            op_set_byte: begin
                result = XMA_BYTE_ONES; // RULE_15
                to_mem = 1'b1;
            end
            op_set_bit: begin
                result = rdata | (8'h01 << bit_sel); // RULE_16
                to_mem = 1'b1;
            end
            op_skip_if_nonzero_bit: begin
                skip_op = 1'b1;
                skip_cond = rdata[bit_sel]; // RULE_17
            end
            op_skip_if_nonzero: begin
                skip_op = 1'b1;
                skip_cond = (rdata != 8'h00); // RULE_18
            end
            op_nibble_swap_mem, op_nibble_swap_to_acc: begin
                result = {rdata[3:0], rdata[7:4]}; // RULE_19
                to_mem = (op == op_nibble_swap_mem);
                to_acc = !to_mem;
            end
            op_skip_if_zero: begin
                skip_op = 1'b1;
                skip_cond = (rdata == 8'h00); // RULE_20
            end
            default: begin
                result = rdata;
            end
        endcase
    end

    // Memory port: the sequencer owns it while busy, APB otherwise
    assign mem_we = busy ? (state == st_exec && to_mem) : (apb_wr && paddr == XMA_OFS_MEM_DATA);
    assign mem_addr = busy ? op_addr : mem_addr_reg[ADDR_W-1:0]; // RULE_21
    assign mem_wdata = busy ? result : pwdata[7:0];

    xma_data_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(XMA_DATA_W)
    ) u_mem (
        .pclk(pclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(rdata)
    );

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (apb_wr && !refuse && paddr == XMA_OFS_CMD) begin
                        state <= st_fetch;
                    end
                end
                st_fetch: state <= st_exec;
                st_exec: state <= skip_op ? st_dummy : st_idle; // RULE_14
                st_dummy: state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= op_rotate_left_to_acc;
            bit_sel <= 3'h0;
            op_addr <= '0;
        end else if (state == st_idle && apb_wr && !refuse && paddr == XMA_OFS_CMD) begin
            op <= xma_op_t'(pwdata[XMA_CMD_OP_LSB +: 5]);
            bit_sel <= pwdata[XMA_CMD_BIT_LSB +: 3];
            op_addr <= pwdata[XMA_CMD_ADDR_LSB +: ADDR_W]; // RULE_21
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= XMA_ACC_RST;
        end else if (state == st_exec && to_acc) begin
            acc <= result;
        end else if (!busy && apb_wr && paddr == XMA_OFS_ACC && pstrb[0]) begin
            acc <= pwdata[7:0];
        end
    end

    // Flags: carry on rotates through carry and subtracts, the rest on subtracts only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {chained_zero_flag, signed_compare_flag, overflow_flag, zero, aux_carry_flag, carry} <= XMA_FLAGS_RST;
        end else if (state == st_exec && sub_op) begin
            carry <= next_carry; // RULE_08
            aux_carry_flag <= !nib_diff[4];
            zero <= (diff[7:0] == 8'h00);
            overflow_flag <= (acc[7] ^ rdata[7]) & (acc[7] ^ diff[7]);
            signed_compare_flag <= ((acc[7] ^ rdata[7]) & (acc[7] ^ diff[7])) ^ diff[7];
            // Borrow form chains zero across bytes of a multi-byte subtract
            chained_zero_flag <= (diff[7:0] == 8'h00) && (borrow_in ? 1'b0 : (op == op_subtract_to_acc
                || op == op_subtract_to_mem || chained_zero_flag)); // RULE_07 RULE_09
        end else if (state == st_exec && carry_op) begin
            carry <= next_carry; // RULE_02 RULE_03 RULE_06
        end else if (!busy && apb_wr && paddr == XMA_OFS_STATUS && pstrb[0]) begin
            {chained_zero_flag, signed_compare_flag, overflow_flag, zero, aux_carry_flag, carry} <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_reg <= XMA_MEM_ADDR_RST;
        end else if (!busy && apb_wr && paddr == XMA_OFS_MEM_ADDR && pstrb[0]) begin
            mem_addr_reg <= pwdata[7:0];
        end
    end

    // Skip outcome: one pulse during the dummy cycle tells the sequencer to step past
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_next <= 1'b0;
            last_skip <= 1'b0;
            last_cycles <= 2'h0;
            skips <= XMA_SKIPS_RST;
        end else begin
            skip_next <= (state == st_exec) && skip_op && skip_cond; // RULE_22
            if (state == st_exec) begin
                last_skip <= skip_op && skip_cond;
                last_cycles <= skip_op ? XMA_CYC_SKIP : XMA_CYC_PLAIN; // RULE_14
                if (skip_op && skip_cond) begin
                    skips <= skips + 16'h0001;
                end
            end
        end
    end

    // Captured at setup; a memory read needs MEM_ADDR settled one cycle before it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            case (paddr)
                XMA_OFS_ACC: prdata <= {24'h00_0000, acc};
                XMA_OFS_STATUS: prdata <= {18'h0_0000, last_cycles, 2'h0, last_skip, busy, 2'h0,
                    chained_zero_flag, signed_compare_flag, overflow_flag, zero, aux_carry_flag, carry};
                XMA_OFS_MEM_ADDR: prdata <= {24'h00_0000, mem_addr_reg};
                XMA_OFS_MEM_DATA: prdata <= {24'h00_0000, rdata}; // RULE_21
                XMA_OFS_SKIPS: prdata <= {16'h0000, skips};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    rot_left_acc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        (state == st_exec && op == op_rotate_left_to_acc) |=>
            (acc == {$past(rdata[6:0]), $past(rdata[7])}) && $stable(carry))
        else $error("rotate left to accumulator wrong");

    rlc_mem_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        (state == st_exec && op == op_rotate_left_carry_mem) |->
            mem_we && (mem_wdata == {rdata[6:0], carry}) ##1 (carry == $past(rdata[7])))
        else $error("rotate left through carry wrong");

    rot_right_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        (state == st_exec && op == op_rotate_right_mem) |->
            mem_we && (mem_wdata == {rdata[0], rdata[7:1]}) ##1 $stable(carry) && $stable(zero))
        else $error("rotate right wrong");

    rrc_acc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        (state == st_exec && op == op_rotate_right_carry_to_acc) |=>
            (acc == {$past(carry), $past(rdata[7:1])}) && (carry == $past(rdata[0])))
        else $error("rotate right through carry wrong");

    sub_carry_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        (state == st_exec && op == op_subtract_to_acc) |=>
            (carry == ($past(acc) >= $past(rdata))) && (acc == $past(acc) - $past(rdata)))
        else $error("subtract carry wrong");

    skip_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        (state == st_exec && skip_op) |=> (state == st_dummy) ##1 (state == st_idle))
        else $error("skip instruction not two cycles");

    set_byte_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
        (state == st_exec && op == op_set_byte) |-> mem_we && (mem_wdata == 8'hff))
        else $error("byte set wrong");

    swap_acc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
        (state == st_exec && op == op_nibble_swap_to_acc) |->
            !mem_we ##1 (acc == {$past(rdata[3:0]), $past(rdata[7:4])}))
        else $error("nibble swap wrong");

    dec_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        (state == st_exec && op == op_decrement_skip_zero) |=> (skip_next == ($past(rdata) == 8'h01)))
        else $error("decrement skip wrong");

    isz_acc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        (state == st_exec && op == op_increment_skip_zero_acc) |->
            !mem_we ##1 (acc == $past(rdata) + 8'h01) && (skip_next == (acc == 8'h00)))
        else $error("increment skip to accumulator wrong");
endmodule : xma_alu

// ---- include/xma_pkg.sv ----
// Shared constants and types for the extended memory ALU block
package xma_pkg;
    localparam int XMA_DATA_W = 8;
    localparam int XMA_ADDR_W = 8;

    // APB register byte offsets
    localparam logic [7:0] XMA_OFS_CMD = 8'h00;
    localparam logic [7:0] XMA_OFS_ACC = 8'h04;
    localparam logic [7:0] XMA_OFS_STATUS = 8'h08;
    localparam logic [7:0] XMA_OFS_MEM_ADDR = 8'h0c;
    localparam logic [7:0] XMA_OFS_MEM_DATA = 8'h10;
    localparam logic [7:0] XMA_OFS_SKIPS = 8'h14;

    // Command register fields
    localparam int XMA_CMD_OP_LSB = 0;
    localparam int XMA_CMD_BIT_LSB = 8;
    localparam int XMA_CMD_ADDR_LSB = 16;

    // Status register fields
    localparam int XMA_ST_CARRY = 0;
    localparam int XMA_ST_AUX = 1;
    localparam int XMA_ST_ZERO = 2;
    localparam int XMA_ST_OVF = 3;
    localparam int XMA_ST_SC = 4;
    localparam int XMA_ST_CZ = 5;
    localparam int XMA_ST_BUSY = 8;
    localparam int XMA_ST_SKIP = 9;
    localparam int XMA_ST_CYC_LSB = 12;

    // Reset values
    localparam logic [7:0] XMA_ACC_RST = 8'h00;
    localparam logic [5:0] XMA_FLAGS_RST = 6'h00;
    localparam logic [7:0] XMA_MEM_ADDR_RST = 8'h00;
    localparam logic [15:0] XMA_SKIPS_RST = 16'h0000;

    // Instruction cycles and byte-set value
    localparam logic [1:0] XMA_CYC_PLAIN = 2'h1;
    localparam logic [1:0] XMA_CYC_SKIP = 2'h2;
    localparam logic [7:0] XMA_BYTE_ONES = 8'hff;

    typedef enum logic [4:0] {
        op_rotate_left_to_acc = 5'h00,
        op_rotate_left_carry_mem = 5'h01,
        op_rotate_left_carry_to_acc = 5'h02,
        op_rotate_right_mem = 5'h03,
        op_rotate_right_to_acc = 5'h04,
        op_rotate_right_carry_mem = 5'h05,
        op_rotate_right_carry_to_acc = 5'h06,
        op_subtract_borrow_to_acc = 5'h07,
        op_subtract_borrow_to_mem = 5'h08,
        op_subtract_to_acc = 5'h09,
        op_subtract_to_mem = 5'h0a,
        op_decrement_skip_zero = 5'h0b,
        op_decrement_skip_zero_acc = 5'h0c,
        op_increment_skip_zero = 5'h0d,
        op_increment_skip_zero_acc = 5'h0e,
        op_set_byte = 5'h0f,
        op_set_bit = 5'h10,
        op_skip_if_nonzero_bit = 5'h11,
        op_skip_if_nonzero = 5'h12,
        op_nibble_swap_mem = 5'h13,
        op_nibble_swap_to_acc = 5'h14,
        op_skip_if_zero = 5'h15
    } xma_op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_fetch = 2'b01,
        st_exec = 2'b10,
        st_dummy = 2'b11
    } xma_state_t;
endpackage : xma_pkg

// ---- design/xma_data_mem.sv ----
// Data memory with synchronous write and registered read data
`timescale 1ns/100ps
module xma_data_mem #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    initial begin
        if (ADDR_W < 1 || ADDR_W > 12 || DATA_W < 1) begin
            $error("xma_data_mem: unsupported size");
        end
    end

    // No reset on the array; read data still comes from a flop
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= mem[addr];
    end
endmodule : xma_data_mem

// ---- tb/xma_apb_host.sv ----
// APB requester model standing in for the core sequencer
`timescale 1ns/100ps
module xma_apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the very edge that samples pready high
        do begin
            @(posedge pclk);
            rdy = pready;
            q = prdata;
            e = pslverr;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines do not keep the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : xma_apb_host

// ---- tb/extended_memory_alu_ops_tb.sv ----
// Self-checking bench for the extended memory ALU block
`timescale 1ns/100ps
module extended_memory_alu_ops_tb;
    import xma_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy, skip_next, e, e_skip, e_two;
    logic [7:0] paddr, e_acc, e_mem;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [5:0] e_fl;
    logic [15:0] n_skip = 16'h0000;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int bcnt = 0;
    int scnt = 0;

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        bcnt <= bcnt + int'(busy === 1'b1);
        scnt <= scnt + int'(skip_next === 1'b1);
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    xma_apb_host mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    xma_alu DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy), .skip_next(skip_next));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mst.xfer(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        mst.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd

    // Optionally pokes ACC while busy, which must be refused
    task automatic run(input xma_op_t op, input logic [2:0] b, input logic [7:0] a, input logic poke);
        wr(XMA_OFS_CMD, {8'h00, a, 5'h00, b, 3'h0, op});
        if (poke) begin
            wr(XMA_OFS_ACC, 32'h77);
            chk(e, 1'b1);
        end
        for (int i = 0; i < 20; i++) begin
            rd(XMA_OFS_STATUS);
            if (q[XMA_ST_BUSY] === 1'b0) break;
        end
    endtask : run

    task automatic model(input xma_op_t op, input logic [2:0] b, input logic [7:0] a, input logic [7:0] m,
                         input logic [5:0] f);
        logic [8:0] r;
        logic [4:0] lo;
        logic brw, bin, z, ov;
        brw = op inside {op_subtract_borrow_to_acc, op_subtract_borrow_to_mem};
        bin = brw & ~f[0];
        r = {1'b0, a} - {1'b0, m} - {8'h00, bin};
        lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
        z = (r[7:0] == 8'h00);
        ov = (a[7] ^ m[7]) & (r[7] ^ a[7]);
        e_acc = a;
        e_mem = m;
        e_fl = f;
        e_skip = 1'b0;
        case (op)
            op_rotate_left_to_acc: e_acc = {m[6:0], m[7]};
            op_rotate_left_carry_mem: {e_fl[0], e_mem} = {m, f[0]};
            op_rotate_left_carry_to_acc: {e_fl[0], e_acc} = {m, f[0]};
            op_rotate_right_mem: e_mem = {m[0], m[7:1]};
            op_rotate_right_to_acc: e_acc = {m[0], m[7:1]};
            op_rotate_right_carry_mem: {e_mem, e_fl[0]} = {f[0], m};
            op_rotate_right_carry_to_acc: {e_acc, e_fl[0]} = {f[0], m};
            op_subtract_borrow_to_acc, op_subtract_to_acc: e_acc = r[7:0];
            op_subtract_borrow_to_mem, op_subtract_to_mem: e_mem = r[7:0];
            op_decrement_skip_zero: e_mem = m - 8'h01;
            op_decrement_skip_zero_acc: e_acc = m - 8'h01;
            op_increment_skip_zero: e_mem = m + 8'h01;
            op_increment_skip_zero_acc: e_acc = m + 8'h01;
            op_set_byte: e_mem = XMA_BYTE_ONES;
            op_set_bit: e_mem[b] = 1'b1;
            op_skip_if_nonzero_bit: e_skip = m[b];
            op_skip_if_nonzero: e_skip = |m;
            op_nibble_swap_mem: e_mem = {m[3:0], m[7:4]};
            op_nibble_swap_to_acc: e_acc = {m[3:0], m[7:4]};
            op_skip_if_zero: e_skip = ~|m;
            default: ;
        endcase
        if (op inside {op_decrement_skip_zero, op_decrement_skip_zero_acc}) e_skip = (m - 8'h01) == 8'h00;
        if (op inside {op_increment_skip_zero, op_increment_skip_zero_acc}) e_skip = (m + 8'h01) == 8'h00;
        if (op inside {[op_subtract_borrow_to_acc:op_subtract_to_mem]}) begin
            e_fl = {brw ? (~bin & z & f[5]) : z, ov ^ r[7], ov, z, ~lo[4], ~r[8]};
        end
        e_two = op inside {[op_decrement_skip_zero:op_increment_skip_zero_acc], op_skip_if_nonzero_bit,
                           op_skip_if_nonzero, op_skip_if_zero};
    endtask : model

    initial begin
        // Fields: acc, memory byte, address (low bits pick the bit), flags
        logic [31:0] vec [4] = '{32'h10200000, 32'h80015821, 32'h05fffb3f, 32'h00008521};
        logic [7:0] ofs [4] = '{XMA_OFS_ACC, XMA_OFS_STATUS, XMA_OFS_MEM_ADDR, XMA_OFS_SKIPS};
        logic [7:0] a, m, ad;
        int b0, s0;
        xma_op_t op;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(q, 32'h0);
        end
        wr(8'h18, 32'h1);
        chk(e, 1'b1);
        wr(XMA_OFS_SKIPS, 32'h5);
        chk(e, 1'b1);
        run(op_set_byte, 3'h0, 8'h40, 1'b0);
        // Skip-type op stays busy through the poke's access phase
        run(op_skip_if_zero, 3'h0, 8'h40, 1'b1);
        rd(XMA_OFS_ACC);
        chk(q, 32'h0);
        foreach (vec[v]) begin
            for (int k = 0; k <= 21; k++) begin
                op = xma_op_t'(k);
                {a, m, ad} = vec[v][31:8];
                wr(XMA_OFS_MEM_ADDR, {24'h0, ad});
                wr(XMA_OFS_MEM_DATA, {24'h0, m});
                wr(XMA_OFS_ACC, {24'h0, a});
                wr(XMA_OFS_STATUS, {26'h0, vec[v][5:0]});
                model(op, ad[2:0], a, m, vec[v][5:0]);
                b0 = bcnt;
                s0 = scnt;
                run(op, ad[2:0], ad, 1'b0);
                chk(bcnt - b0, e_two ? 3 : 2);
                chk(scnt - s0, {31'h0, e_skip});
                rd(XMA_OFS_STATUS);
                chk(q, {18'h0, e_two ? XMA_CYC_SKIP : XMA_CYC_PLAIN, 2'b00, e_skip, 3'b000, e_fl});
                rd(XMA_OFS_ACC);
                chk(q, {24'h0, e_acc});
                n_skip = n_skip + {15'h0, e_skip};
                rd(XMA_OFS_SKIPS);
                chk(q, {16'h0, n_skip});
                // Memory checked through a swap into ACC and by direct read back
                run(op_nibble_swap_to_acc, 3'h0, ad, 1'b0);
                rd(XMA_OFS_ACC);
                chk(q, {24'h0, e_mem[3:0], e_mem[7:4]});
                rd(XMA_OFS_MEM_DATA);
                chk(q, {24'h0, e_mem});
            end
        end
        give_verdict();
    end
endmodule : extended_memory_alu_ops_tb
